// ### dpr_params.svh
`ifndef DPR_PARAMS_SVH
`define DPR_PARAMS_SVH
// Register byte addresses on the Avalon-MM slave
`define DPR_REG_CTRL 4'h0
`define DPR_REG_ADDR 4'h4
`define DPR_REG_WDATA 4'h8
`define DPR_REG_RDATA 4'hC
// Control register fields
`define DPR_CTRL_GO_BIT 0
`define DPR_CTRL_WRITE_BIT 1
`define DPR_CTRL_TOKEN_BIT 2
`define DPR_CTRL_UPPER_BIT 3
`define DPR_CTRL_LOWER_BIT 4
// Status fields, read through the control register
`define DPR_STAT_BUSY_BIT 8
`define DPR_STAT_DONE_BIT 9
`define DPR_STAT_COLL_BIT 10
`define DPR_STAT_MASTER_BIT 11
// Phase lengths in ns, turned into cycles of the 100 ns clock
`define DPR_CLK_NS 100
`define DPR_SETUP_NS 100
`define DPR_STROBE_NS 100
`define DPR_HOLD_NS 100
`define DPR_CYC(ns) (((ns) + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_CNT_W 4
`endif

// ### dpr_pkg.sv
package dpr_pkg;
  typedef enum logic [2:0] {
    DPR_IDLE,
    DPR_SETUP,
    DPR_STROBE,
    DPR_HOLD,
    DPR_RELEASE
  } dpr_state_e;
endpackage : dpr_pkg

// ### dpr_seq_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dpr_seq_if #(parameter int AW = 13, parameter int DW = 16);
  logic start;
  logic is_write;
  logic is_token;
  logic upper_en;
  logic lower_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic done;
  logic busy;
  logic [DW-1:0] rdata;
  logic collided;
  modport ctrl (output start, is_write, is_token, upper_en, lower_en, addr, wdata,
    input done, busy, rdata, collided);
  modport seq (input start, is_write, is_token, upper_en, lower_en, addr, wdata,
    output done, busy, rdata, collided);
endinterface : dpr_seq_if
`default_nettype wire

// ### dpr_pin_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpr_params.svh"
module dpr_pin_seq
  import dpr_pkg::*;
#(
  parameter int AW = 13,
  parameter int DW = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  dpr_seq_if.seq cmd,
  output logic [AW-1:0] port_addr,
  output logic port_select_n,
  output logic token_select_n,
  output logic write_n,
  output logic out_enable_n,
  output logic upper_lane_n,
  output logic lower_lane_n,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  input wire logic collision_in_n,
  output logic collision_out_n,
  output logic collision_oe,
  input wire logic master_mode
);
  localparam logic [`DPR_CNT_W-1:0] SETUP_CYC = `DPR_CNT_W'(`DPR_CYC(`DPR_SETUP_NS));
  localparam logic [`DPR_CNT_W-1:0] STROBE_CYC = `DPR_CNT_W'(`DPR_CYC(`DPR_STROBE_NS));
  localparam logic [`DPR_CNT_W-1:0] HOLD_CYC = `DPR_CNT_W'(`DPR_CYC(`DPR_HOLD_NS));

  dpr_state_e state, next_state;
  logic [`DPR_CNT_W-1:0] cnt, next_cnt;
  logic [AW-1:0] next_port_addr;
  logic next_port_select_n, next_token_select_n, next_write_n, next_out_enable_n;
  logic next_upper_lane_n, next_lower_lane_n, next_data_oe;
  logic [DW-1:0] next_data_out, rdata, next_rdata;
  logic wr, next_wr, tok, next_tok, coll, next_coll, done, next_done;

  // Collision pin is only an input on a slave device; host drives it never
  assign collision_out_n = 1'b1;
  assign collision_oe = 1'b0;
  assign cmd.rdata = rdata;
  assign cmd.done = done;
  assign cmd.busy = (state != DPR_IDLE);
  assign cmd.collided = coll;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_port_addr = port_addr;
    next_port_select_n = port_select_n;
    next_token_select_n = token_select_n;
    next_write_n = write_n;
    next_out_enable_n = out_enable_n;
    next_upper_lane_n = upper_lane_n;
    next_lower_lane_n = lower_lane_n;
    next_data_out = data_out;
    next_data_oe = data_oe;
    next_rdata = rdata;
    next_wr = wr;
    next_tok = tok;
    next_coll = coll;
    next_done = 1'b0;
    case (state)
      DPR_IDLE: begin
        if (cmd.start) begin
          // Address moves only while write strobe is high
          next_port_addr = cmd.addr;
          next_wr = cmd.is_write;
          next_tok = cmd.is_token;
          next_coll = 1'b0;
          // Token request is a low on data bit zero
          next_data_out = cmd.is_token ? {{(DW-1){1'b1}}, cmd.wdata[0]} : cmd.wdata;
          next_upper_lane_n = ~cmd.upper_en;
          next_lower_lane_n = ~cmd.lower_en;
          next_cnt = SETUP_CYC;
          next_state = DPR_SETUP;
        end
      end
      DPR_SETUP: begin
        // Select falls one setup time after address, memory and token selects exclusive
        next_port_select_n = tok;
        next_token_select_n = ~tok;
        next_out_enable_n = wr;
        if (cnt > `DPR_CNT_W'(1)) begin
          next_cnt = cnt - `DPR_CNT_W'(1);
        end else begin
          // Drive data only on writes, read keeps strobe high
          next_write_n = ~wr;
          next_data_oe = wr;
          next_cnt = STROBE_CYC;
          next_state = DPR_STROBE;
        end
      end
      DPR_STROBE: begin
        // Slave writes are held off while the collision input is low
        if (!master_mode && !collision_in_n && wr) begin
          next_coll = 1'b1;
        end else if (cnt > `DPR_CNT_W'(1)) begin
          next_cnt = cnt - `DPR_CNT_W'(1);
        end else begin
          next_rdata = data_in;
          if (master_mode && !collision_in_n) begin
            next_coll = 1'b1;
          end
          next_write_n = 1'b1;
          next_cnt = HOLD_CYC;
          next_state = DPR_HOLD;
        end
      end
      DPR_HOLD: begin
        // Selects rise after strobe so address and data hold stay met
        next_port_select_n = 1'b1;
        next_token_select_n = 1'b1;
        next_out_enable_n = 1'b1;
        next_state = DPR_RELEASE;
      end
      DPR_RELEASE: begin
        if (cnt > `DPR_CNT_W'(1)) begin
          next_cnt = cnt - `DPR_CNT_W'(1);
        end else begin
          next_data_oe = 1'b0;
          next_upper_lane_n = 1'b1;
          next_lower_lane_n = 1'b1;
          next_done = 1'b1;
          next_state = DPR_IDLE;
        end
      end
      default: next_state = DPR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= DPR_IDLE;
      cnt <= '0;
      port_addr <= '0;
      port_select_n <= 1'b1;
      token_select_n <= 1'b1;
      write_n <= 1'b1;
      out_enable_n <= 1'b1;
      upper_lane_n <= 1'b1;
      lower_lane_n <= 1'b1;
      data_out <= '0;
      data_oe <= 1'b0;
      rdata <= '0;
      wr <= 1'b0;
      tok <= 1'b0;
      coll <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      cnt <= next_cnt;
      port_addr <= next_port_addr;
      port_select_n <= next_port_select_n;
      token_select_n <= next_token_select_n;
      write_n <= next_write_n;
      out_enable_n <= next_out_enable_n;
      upper_lane_n <= next_upper_lane_n;
      lower_lane_n <= next_lower_lane_n;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      rdata <= next_rdata;
      wr <= next_wr;
      tok <= next_tok;
      coll <= next_coll;
      done <= next_done;
    end
  end
endmodule : dpr_pin_seq
`default_nettype wire

// ### dpr_host.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "dpr_params.svh"
// Contract
// - Host keeps write strobe high for every read cycle.
// - Host changes address only while write strobe is high.
// - Address is valid no later than select falling.
// - Token reads always pulse the token select, never continuous.
// - Memory select stays high during token write and read-back.
// - Host never drives data lines while device drives them.
// - Memory access uses port select; token access uses token select only.
module dpr_host
  import dpr_pkg::*;
#(
  parameter int AW = 13,
  parameter int DW = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [AW-1:0] port_addr,
  output logic port_select_n,
  output logic token_select_n,
  output logic write_n,
  output logic out_enable_n,
  output logic upper_lane_n,
  output logic lower_lane_n,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  input wire logic collision_in_n,
  output logic collision_out_n,
  output logic collision_oe,
  output logic master_select
);
  dpr_seq_if #(.AW(AW), .DW(DW)) seq_bus ();

  logic [4:0] ctrl, next_ctrl;
  logic [AW-1:0] addr, next_addr;
  logic [DW-1:0] wdata, next_wdata;
  logic done_flag, next_done_flag;
  logic coll_flag, next_coll_flag;
  logic go, next_go;
  logic ack, next_ack;
  logic [31:0] rd, next_rd;
  logic [31:0] status_word;
  logic access;
  logic wr_take;
  logic rd_take;
  logic clr_done;
  logic clr_coll;

  // Host is one port of a standalone device, so the part is run as master
  assign master_select = 1'b1;
  // Keep clk_en high across a bus transfer: a frozen acknowledge would answer the next request
  assign access = (avs_read | avs_write) & ~ack;
  assign avs_waitrequest = access;
  assign wr_take = access & clk_en & avs_write;
  assign rd_take = access & clk_en & ~avs_write;
  assign clr_done = wr_take & (avs_address == `DPR_REG_CTRL) & avs_byteenable[1] & avs_writedata[`DPR_STAT_DONE_BIT];
  assign clr_coll = wr_take & (avs_address == `DPR_REG_CTRL) & avs_byteenable[1] & avs_writedata[`DPR_STAT_COLL_BIT];
  assign avs_readdata = rd;
  assign seq_bus.start = go;
  assign seq_bus.is_write = ctrl[`DPR_CTRL_WRITE_BIT];
  assign seq_bus.is_token = ctrl[`DPR_CTRL_TOKEN_BIT];
  assign seq_bus.upper_en = ctrl[`DPR_CTRL_UPPER_BIT];
  assign seq_bus.lower_en = ctrl[`DPR_CTRL_LOWER_BIT];
  assign seq_bus.addr = addr;
  assign seq_bus.wdata = wdata;

  // Bus handshake: one wait state, the answer stands at the next enabled edge
  always_comb begin
    next_ack = access & clk_en;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack <= 1'b0;
    end else if (clk_en) begin
      ack <= next_ack;
    end
  end

  // Command registers, changed only by a taken write
  always_comb begin
    next_ctrl = ctrl;
    next_addr = addr;
    next_wdata = wdata;
    next_go = 1'b0;
    if (wr_take) begin
      case (avs_address)
        `DPR_REG_CTRL: begin
          if (avs_byteenable[0]) begin
            // GO is a strobe, so it never reads back as set
            next_ctrl = avs_writedata[4:0];
            next_ctrl[`DPR_CTRL_GO_BIT] = 1'b0;
            // Start ignored while a cycle runs or is about to start
            next_go = avs_writedata[`DPR_CTRL_GO_BIT] & ~seq_bus.busy & ~go;
          end
        end
        `DPR_REG_ADDR: next_addr = avs_writedata[AW-1:0];
        `DPR_REG_WDATA: next_wdata = avs_writedata[DW-1:0];
        default: next_go = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl <= 5'h00;
      addr <= '0;
      wdata <= '0;
      go <= 1'b0;
    end else if (clk_en) begin
      ctrl <= next_ctrl;
      addr <= next_addr;
      wdata <= next_wdata;
      go <= next_go;
    end
  end

  // Clears are write-one on the second byte of the control offset
  always_comb begin
    next_done_flag = done_flag;
    next_coll_flag = coll_flag;
    if (clr_done) begin
      next_done_flag = 1'b0;
    end
    if (clr_coll) begin
      next_coll_flag = 1'b0;
    end
    // Set by a finished cycle wins over a software clear in the same cycle
    if (seq_bus.done) begin
      next_done_flag = 1'b1;
    end
    if (seq_bus.done && seq_bus.collided) begin
      next_coll_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      done_flag <= 1'b0;
      coll_flag <= 1'b0;
    end else if (clk_en) begin
      done_flag <= next_done_flag;
      coll_flag <= next_coll_flag;
    end
  end

  // Status word seen at the control offset
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[4:0] = ctrl;
    status_word[`DPR_STAT_BUSY_BIT] = seq_bus.busy;
    status_word[`DPR_STAT_DONE_BIT] = done_flag;
    status_word[`DPR_STAT_COLL_BIT] = coll_flag;
    status_word[`DPR_STAT_MASTER_BIT] = master_select;
  end

  // Read data is registered so it stands at the edge that ends the wait
  always_comb begin
    next_rd = rd;
    if (rd_take) begin
      case (avs_address)
        `DPR_REG_CTRL: next_rd = status_word;
        `DPR_REG_ADDR: next_rd = 32'(addr);
        `DPR_REG_WDATA: next_rd = 32'(wdata);
        // Token bit zero low means this port holds it
        `DPR_REG_RDATA: next_rd = 32'(seq_bus.rdata);
        default: next_rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd <= 32'h0000_0000;
    end else if (clk_en) begin
      rd <= next_rd;
    end
  end

  // Phases are whole clock cycles, so a slower part needs longer phase times
  dpr_pin_seq #(.AW(AW), .DW(DW)) dpr_pin_seq_i (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .cmd(seq_bus.seq),
    .port_addr(port_addr),
    .port_select_n(port_select_n),
    .token_select_n(token_select_n),
    .write_n(write_n),
    .out_enable_n(out_enable_n),
    .upper_lane_n(upper_lane_n),
    .lower_lane_n(lower_lane_n),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .collision_in_n(collision_in_n),
    .collision_out_n(collision_out_n),
    .collision_oe(collision_oe),
    .master_mode(master_select)
  );
endmodule : dpr_host
`default_nettype wire

// ### dpr_host_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dpr_host_properties #(
  parameter int AW = 13
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [AW-1:0] port_addr,
  input wire logic port_select_n,
  input wire logic token_select_n,
  input wire logic write_n,
  input wire logic upper_lane_n,
  input wire logic lower_lane_n,
  input wire logic data_oe,
  input wire logic collision_in_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  read_strobe_high_a: assert property (!data_oe |-> write_n)
    else $error("write strobe low without write data");
  addr_move_idle_a: assert property ($changed(port_addr) |-> write_n && $past(write_n))
    else $error("address moved during a write");
  addr_before_sel_a: assert property ($fell(port_select_n) || $fell(token_select_n) |-> $stable(port_addr))
    else $error("address not settled at select fall");
  token_pulse_a: assert property ($fell(token_select_n) |-> ##[1:8] $rose(token_select_n))
    else $error("token select held low too long");
  select_excl_a: assert property (!token_select_n |-> port_select_n)
    else $error("memory select low during token access");
  data_turn_a: assert property ($rose(data_oe) |-> $fell(write_n))
    else $error("data driven outside a write strobe");
  lane_needed_a: assert property (!port_select_n |-> !(upper_lane_n && lower_lane_n))
    else $error("memory select without any byte lane");
  cover property ($fell(token_select_n));
  cover property ($rose(data_oe) && !port_select_n);
  cover property (!collision_in_n && !port_select_n);
endmodule : dpr_host_properties
bind dpr_host dpr_host_properties #(.AW(AW)) dpr_host_properties_i (.sys_clk, .reset, .port_addr, .port_select_n,
  .token_select_n, .write_n, .upper_lane_n, .lower_lane_n, .data_oe, .collision_in_n);
`default_nettype wire

// ### dpr_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
module dpr_ram_model (
  input wire logic sys_clk,
  input wire logic [12:0] port_addr,
  input wire logic port_select_n,
  input wire logic token_select_n,
  input wire logic write_n,
  input wire logic out_enable_n,
  input wire logic upper_lane_n,
  input wire logic lower_lane_n,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  input wire logic master_select,
  input wire logic coll_req,
  output logic [15:0] data_in,
  output logic collision_in_n
);
  logic [15:0] mem [0:8191];
  logic [7:0] tok = 8'hFF;
  logic [15:0] last = 16'h0;
  logic drv;
  logic [15:0] rv;
  // Drives only while the strobe is high, so a select falling with or after it stays off
  assign drv = write_n && !out_enable_n && !(port_select_n && token_select_n);
  assign rv = !port_select_n ? mem[port_addr] : {15'h7FFF, tok[port_addr[2:0]]};
  // Released bus has no pull: show the inverse so stale data never passes
  assign data_in = drv ? rv : ~last;
  // Far port is only a bench knob, so exactly one side sees the flag
  assign collision_in_n = !(master_select && coll_req && !port_select_n);
  always @(posedge sys_clk) if (drv) last <= rv;
  always @(posedge write_n) begin
    // Single requester here, so a request is always granted to exactly one side
    if (data_oe === 1'b1 && !token_select_n) tok[port_addr[2:0]] <= data_out[0];
    if (data_oe === 1'b1 && !port_select_n) begin
      if (!upper_lane_n) mem[port_addr][15:8] <= data_out[15:8];
      if (!lower_lane_n) mem[port_addr][7:0] <= data_out[7:0];
    end
  end
endmodule : dpr_ram_model
`default_nettype wire

// ### dpr_host_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e); end end
module dpr_host_test;
  logic sys_clk = 0;
  logic reset = 1;
  logic [3:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic coll_req = 0;
  logic [31:0] seed = 32'h453B860C;
  int err_count = 0;
  int samples_checked = 0;
  int mdl [int];
  wire [31:0] avs_readdata;
  wire [12:0] port_addr;
  wire [15:0] data_in, data_out;
  wire avs_waitrequest, port_select_n, token_select_n, write_n, out_enable_n, upper_lane_n, lower_lane_n;
  wire data_oe, collision_in_n, master_select, collision_out_n, collision_oe;
  dpr_host dpr_host_i (.sys_clk, .reset, .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .port_addr, .port_select_n, .token_select_n, .write_n,
    .out_enable_n, .upper_lane_n, .lower_lane_n, .data_in, .data_out, .data_oe, .collision_in_n,
    .collision_out_n(collision_out_n), .collision_oe(collision_oe), .master_select);
  dpr_ram_model dpr_ram_model_i (.sys_clk, .port_addr, .port_select_n, .token_select_n, .write_n, .out_enable_n,
    .upper_lane_n, .lower_lane_n, .data_out, .data_oe, .master_select, .coll_req, .data_in, .collision_in_n);
  always #50 sys_clk = ~sys_clk;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic op(input logic [31:0] c, input logic [12:0] a, input logic [15:0] d, output logic [31:0] st,
    output logic [15:0] q);
    logic [31:0] r;
    int n = 0;
    st = 0;
    bus(1'b1, 4'h4, {19'h0, a}, r);
    bus(1'b1, 4'h8, {16'h0, d}, r);
    bus(1'b1, 4'h0, c | 32'h1, r);
    while (st[9] !== 1'b1 && n < 30) begin
      bus(1'b0, 4'h0, 32'h0, st);
      n++;
    end
    `CHK(st[9], 1'b1)
    bus(1'b1, 4'h0, 32'h600, r);
    bus(1'b0, 4'hC, 32'h0, r);
    q = r[15:0];
  endtask : op
  initial begin
    #2000000;
    err_count++;
    stop_test();
  end
  initial begin
    logic [31:0] st;
    logic [31:0] r;
    logic [15:0] q;
    logic [12:0] a;
    logic [15:0] d;
    logic [1:0] ln;
    int m;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, 4'h0, 32'h0, r);
    `CHK(r[11:8], 4'h8)
    op(32'h4, 13'h5, 16'h0, st, q);
    `CHK(q[0], 1'b1)
    for (int i = 0; i < 2; i++) begin
      op(32'h6, 13'h5, 16'(i), st, q);
      op(32'h4, 13'h5, 16'h0, st, q);
      `CHK(q[0], 1'(i))
    end
    for (int i = 0; i < 8; i++) begin
      a = 13'(rnd());
      d = 16'(rnd());
      ln = 2'(rnd() % 3 + 1);
      mdl[a] = int'(16'(rnd()));
      op(32'h1A, a, 16'(mdl[a]), st, q);
      op({27'h0, ln[0], ln[1], 3'h2}, a, d, st, q);
      m = (ln[1] ? 'hFF00 : 0) | (ln[0] ? 'hFF : 0);
      mdl[a] = (mdl[a] & ~m) | (int'(d) & m);
      op(32'h18, a, 16'h0, st, q);
      `CHK(q, 16'(mdl[a]))
    end
    coll_req <= 1'b1;
    op(32'h18, a, 16'h0, st, q);
    `CHK(st[10], 1'b1)
    `CHK({collision_oe, collision_out_n}, 2'b01)
    coll_req <= 1'b0;
    op(32'h18, a, 16'h0, st, q);
    `CHK(st[10], 1'b0)
    stop_test();
  end
endmodule : dpr_host_test
`default_nettype wire
